// ### hw/ppp_port.sv
`default_nettype none
module ppp_port
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       srst,
  // host pins in
  input  wire logic       strobe_n_i,
  input  wire logic       prime_n_i,
  input  wire logic       selin_n_i,
  input  wire logic [7:0] data_i,
  // host pins out
  output logic [7:0]      data_o,
  output logic            data_oe,
  output logic            ack_n_o,
  output logic            busy_o,
  output logic            paper_end_o,
  output logic            select_o,
  output logic            fault_n_o,
  // printer configuration and status
  input  wire logic       prime_en_i,
  input  wire logic       nibble_mode_i,
  input  wire logic       online_i,
  input  wire logic       paper_out_i,
  input  wire logic       alarm_i,
  // received bytes toward the printer core
  output logic            rx_valid_o,
  output logic [7:0]      rx_data_o,
  input  wire logic       rx_ready_i,
  // bytes returned to the host in nibble mode
  input  wire logic       tx_valid_i,
  input  wire logic [7:0] tx_data_i,
  output logic            tx_ready_o,
  // reverse drive of the data lines
  input  wire logic       rev_en_i,
  input  wire logic [7:0] rev_data_i
);
  ppp_sync_if sif ();

  ppp_sync u_sync
  (
    .clk  (clk),
    .srst (srst),
    .sif  (sif)
  );

  assign sif.raw = {selin_n_i, prime_n_i, strobe_n_i, data_i};

  ppp_pkg::ppp_state_t          state_r;
  ppp_pkg::ppp_state_t          state_nxt;
  logic [ppp_pkg::CNT_W-1:0]    cnt_r;
  logic                         stb_prev_r;
  logic [7:0]                   rx_data_r;
  logic [7:0]                   tx_r;
  logic [7:0]                   data_r;
  logic                         data_oe_r;
  logic                         ack_n_r;
  logic                         busy_r;
  logic                         pend_r;
  logic                         sel_r;
  logic                         fault_n_r;
  logic [3:0]                   stat_nxt;
  logic                         ack_n_nxt;

  // settled host inputs
  wire       stb_f     = sif.filt[ppp_pkg::STB_BIT];
  wire       prime_f   = sif.filt[ppp_pkg::PRIME_BIT];
  wire       selin_f   = sif.filt[ppp_pkg::SELIN_BIT];
  wire [7:0] data_f    = sif.filt[7:0];
  wire       stb_fall  = stb_prev_r & ~stb_f;
  wire       input_en  = ~selin_f;
  wire       prime_hit = prime_en_i & ~prime_f;
  wire       is_idle   = (state_r == ppp_pkg::ST_IDLE);
  wire       take_byte = is_idle & ~nibble_mode_i & input_en & online_i
                         & stb_fall;
  wire       start_nib = is_idle & nibble_mode_i & tx_valid_i;
  wire       ack_done  = (cnt_r == ppp_pkg::ACK_LAST);
  wire       nib_done  = (cnt_r == ppp_pkg::NIB_LAST);
  wire       nib_lo    = (state_r == ppp_pkg::ST_NIB_LO)
                         | (state_r == ppp_pkg::ST_ACK_LO);
  wire       nib_hi    = (state_r == ppp_pkg::ST_NIB_HI)
                         | (state_r == ppp_pkg::ST_ACK_HI);

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      ppp_pkg::ST_IDLE:
      begin
        if (take_byte)
          state_nxt = ppp_pkg::ST_HOLD;
        else if (start_nib)
          state_nxt = ppp_pkg::ST_NIB_LO;
      end
      ppp_pkg::ST_HOLD:
        if (rx_ready_i)
          state_nxt = ppp_pkg::ST_ACK;
      ppp_pkg::ST_ACK:
        if (ack_done)
          state_nxt = ppp_pkg::ST_IDLE;
      ppp_pkg::ST_NIB_LO:
        if (nib_done)
          state_nxt = ppp_pkg::ST_ACK_LO;
      ppp_pkg::ST_ACK_LO:
        if (ack_done)
          state_nxt = ppp_pkg::ST_NIB_HI;
      ppp_pkg::ST_NIB_HI:
        if (nib_done)
          state_nxt = ppp_pkg::ST_ACK_HI;
      ppp_pkg::ST_ACK_HI:
        if (ack_done)
          state_nxt = ppp_pkg::ST_IDLE;
      default:
        state_nxt = ppp_pkg::ST_IDLE;
    endcase
  end

  // acknowledge low for the whole ack state
  assign ack_n_nxt = ~((state_nxt == ppp_pkg::ST_ACK)
                     | (state_nxt == ppp_pkg::ST_ACK_LO)
                     | (state_nxt == ppp_pkg::ST_ACK_HI));

  // status lines carry {busy, paper end, select, fault} nibbles
  always_comb
  begin
    case (state_nxt)
      ppp_pkg::ST_NIB_LO,
      ppp_pkg::ST_ACK_LO:
        stat_nxt = (state_r == ppp_pkg::ST_IDLE) ? tx_data_i[3:0]
                                                  : tx_r[3:0];
      ppp_pkg::ST_NIB_HI,
      ppp_pkg::ST_ACK_HI:
        stat_nxt = tx_r[7:4];
      // busy from strobe until acknowledge has ended
      ppp_pkg::ST_HOLD,
      ppp_pkg::ST_ACK:
        stat_nxt = {1'b1, paper_out_i, online_i, ~(alarm_i | paper_out_i)};
      default:
        stat_nxt = {~online_i | nibble_mode_i | ~input_en,
                    paper_out_i, online_i, ~(alarm_i | paper_out_i)};
    endcase
  end

  // prime restarts the interface only while enabled
  always_ff @(posedge clk)
  begin
    if (srst | prime_hit)
    begin
      state_r   <= ppp_pkg::ST_IDLE;
      cnt_r     <= ppp_pkg::CNT_RST;
      ack_n_r   <= 1'b1;
      busy_r    <= 1'b1;
      pend_r    <= 1'b0;
      sel_r     <= 1'b0;
      fault_n_r <= 1'b1;
    end
    else
    begin
      state_r   <= state_nxt;
      cnt_r     <= (state_nxt != state_r) ? ppp_pkg::CNT_RST
                                          : cnt_r + 8'h01;
      ack_n_r   <= ack_n_nxt;
      busy_r    <= stat_nxt[3];
      pend_r    <= stat_nxt[2];
      sel_r     <= stat_nxt[1];
      fault_n_r <= stat_nxt[0];
    end
  end

  // byte captured on the settled strobe edge
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      stb_prev_r <= 1'b1;
      rx_data_r  <= ppp_pkg::DATA_RST;
      tx_r       <= ppp_pkg::DATA_RST;
    end
    else
    begin
      stb_prev_r <= stb_f;
      if (take_byte)
        rx_data_r <= data_f;
      if (start_nib)
        tx_r <= tx_data_i;
    end
  end

  // data lines driven back only in nibble-side operation
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      data_oe_r <= 1'b0;
      data_r    <= ppp_pkg::DATA_RST;
    end
    else
    begin
      data_oe_r <= rev_en_i & nibble_mode_i;
      data_r    <= rev_data_i;
    end
  end

  assign data_o      = data_r;
  assign data_oe     = data_oe_r;
  assign ack_n_o     = ack_n_r;
  assign busy_o      = busy_r;
  assign paper_end_o = pend_r;
  assign select_o    = sel_r;
  assign fault_n_o   = fault_n_r;
  assign rx_valid_o  = (state_r == ppp_pkg::ST_HOLD);
  assign rx_data_o   = rx_data_r;
  assign tx_ready_o  = (state_r == ppp_pkg::ST_ACK_HI) & ack_done;

  // checks; helper counter measures acknowledge width
  logic [ppp_pkg::CNT_W-1:0] ack_len_r;
  always_ff @(posedge clk)
  begin
    if (srst | ack_n_r)
      ack_len_r <= ppp_pkg::CNT_RST;
    else
      ack_len_r <= ack_len_r + 8'h01;
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst | prime_hit);

  sequence s_take;
    is_idle && !nibble_mode_i && input_en && online_i && stb_fall;
  endsequence
  sequence s_held;
    (state_r == ppp_pkg::ST_HOLD) && busy_o;
  endsequence

  a_strobe_capture: assert property (
    s_take |=> s_held and (rx_data_o == $past(data_f)))
    else $error("byte not captured on strobe");
  a_drive_back: assert property (
    (rev_en_i && nibble_mode_i) |=> data_oe && data_o == $past(rev_data_i))
    else $error("data lines not driven back");
  a_ack_width: assert property (
    $rose(ack_n_o) |-> ack_len_r == ppp_pkg::ACK_LAST + 8'h01)
    else $error("acknowledge pulse width wrong");
  a_busy_in_flight: assert property (
    s_take ##1 (state_r == ppp_pkg::ST_HOLD) |-> busy_o)
    else $error("busy low while byte held");
  a_selin_ignore: assert property (
    (is_idle && selin_f && stb_fall && !nibble_mode_i) |=> is_idle)
    else $error("strobe taken while input disabled");
  a_prime_ignored: assert property (
    (!prime_en_i && !prime_f && state_r == ppp_pkg::ST_HOLD
     && !rx_ready_i) |=> state_r == ppp_pkg::ST_HOLD)
    else $error("disabled prime disturbed interface");
  a_nibble_order: assert property (
    nib_lo
    |-> {busy_o, paper_end_o, select_o, fault_n_o} == tx_r[3:0])
    else $error("low nibble wrong on status lines");
  a_nibble_high: assert property (
    nib_hi
    |-> {busy_o, paper_end_o, select_o, fault_n_o} == tx_r[7:4])
    else $error("high nibble wrong on status lines");
  a_busy_over_ack: assert property (
    (state_r == ppp_pkg::ST_ACK) |-> !ack_n_o && busy_o)
    else $error("busy released before acknowledge ended");
endmodule
`default_nettype wire

// ### common/ppp_pkg.sv
`default_nettype none
package ppp_pkg;
  // clock and handshake timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int ACK_TIME_NS   = 1000;
  localparam int NIB_SETUP_NS  = 500;
  // least times round up to whole cycles
  localparam int ACK_CYC = (ACK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int NIB_CYC = (NIB_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W   = 8;
  localparam logic [CNT_W-1:0] ACK_LAST = CNT_W'(ACK_CYC - 1);
  localparam logic [CNT_W-1:0] NIB_LAST = CNT_W'(NIB_CYC - 1);
  localparam logic [CNT_W-1:0] CNT_RST  = 8'h00;

  // synchronised host inputs, packed into one vector
  localparam int SYNC_W    = 11;
  localparam int STB_BIT   = 8;
  localparam int PRIME_BIT = 9;
  localparam int SELIN_BIT = 10;
  localparam logic [SYNC_W-1:0] SYNC_IDLE = 11'h700;

  // pin levels after reset
  localparam logic [7:0] DATA_RST = 8'h00;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_HOLD,
    ST_ACK,
    ST_NIB_LO,
    ST_ACK_LO,
    ST_NIB_HI,
    ST_ACK_HI
  } ppp_state_t;
endpackage
`default_nettype wire

// ### common/ppp_sync_if.sv
`default_nettype none
interface ppp_sync_if;
  logic [ppp_pkg::SYNC_W-1:0] raw;
  logic [ppp_pkg::SYNC_W-1:0] filt;
  modport sync (input raw, output filt);
  modport user (output raw, input filt);
endinterface
`default_nettype wire

// ### hw/ppp_sync.sv
`default_nettype none
module ppp_sync
(
  // clock and reset
  input  wire logic clk,
  input  wire logic srst,
  // raw pins in, settled levels out
  ppp_sync_if.sync  sif
);
  genvar i;
  generate
    for (i = 0; i < ppp_pkg::SYNC_W; i++)
    begin : g_bit
      logic s1_r;
      logic s2_r;
      logic s3_r;
      logic filt_r;
      // a change only counts once the second and third stages agree
      always_ff @(posedge clk)
      begin
        if (srst)
        begin
          s1_r   <= ppp_pkg::SYNC_IDLE[i];
          s2_r   <= ppp_pkg::SYNC_IDLE[i];
          s3_r   <= ppp_pkg::SYNC_IDLE[i];
          filt_r <= ppp_pkg::SYNC_IDLE[i];
        end
        else
        begin
          s1_r <= sif.raw[i];
          s2_r <= s1_r;
          s3_r <= s2_r;
          if (s2_r == s3_r)
            filt_r <= s3_r;
        end
      end
      assign sif.filt[i] = filt_r;
    end
  endgenerate
endmodule
`default_nettype wire

// ### testbench/ppp_host_model.sv
`default_nettype none
module ppp_host_model
(
  // clock and printer answer
  input  wire logic       clk,
  input  wire logic       busy,
  // host pins
  output logic            strobe_n,
  output logic [7:0]      data
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    strobe_n = 1'b1;
    data     = 8'h00;
  end

  // byte then strobe, once busy clears if wait_busy is set
  task automatic send(input logic [7:0] b, input logic wait_busy);
    int n;
    n = 0;
    // busy is looked at off the edge that launches it
    while (wait_busy && busy !== 1'b0 && n < 2000)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    @(posedge clk);
    #1 data = b;
    @(posedge clk);
    #1 strobe_n = 1'b0;
    repeat (8) @(posedge clk);
    #1 strobe_n = 1'b1;
    repeat (6) @(posedge clk);
    // released lines must not keep showing the old byte
    #1 data = ~b;
  endtask
endmodule
`default_nettype wire

// ### testbench/parallel_printer_port_tb.sv
`default_nettype none
module parallel_printer_port_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic       clk, srst, prime_n, selin_n, prime_en, nib, online;
  logic       paper_out, alarm, rx_ready, tx_valid, rev_en, strobe_n;
  logic [7:0] tx_data, rev_data, host_data, data_o, rx_data, b;
  logic       data_oe, ack_n, busy, paper_end, sel, fault_n;
  logic       rx_valid, tx_ready, seen_ready;
  logic [7:0] c;
  wire  [7:0] data_w;
  int         miscompares, checks_done, cyc;
  int         gap;

  // two-way data wire: printer wins while it drives
  assign data_w = data_oe ? data_o : host_data;

  ppp_host_model host (.clk(clk), .busy(busy), .strobe_n(strobe_n),
    .data(host_data));

  ppp_port DUT (.clk(clk), .srst(srst), .strobe_n_i(strobe_n),
    .prime_n_i(prime_n), .selin_n_i(selin_n), .data_i(data_w),
    .data_o(data_o), .data_oe(data_oe), .ack_n_o(ack_n), .busy_o(busy),
    .paper_end_o(paper_end), .select_o(sel), .fault_n_o(fault_n),
    .prime_en_i(prime_en), .nibble_mode_i(nib), .online_i(online),
    .paper_out_i(paper_out), .alarm_i(alarm), .rx_valid_o(rx_valid),
    .rx_data_o(rx_data), .rx_ready_i(rx_ready), .tx_valid_i(tx_valid),
    .tx_data_i(tx_data), .tx_ready_o(tx_ready), .rev_en_i(rev_en),
    .rev_data_i(rev_data));

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic conclude();
    $display("checks %0d, mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      miscompares++;
      conclude();
    end
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // low time of the next acknowledge, noting any send-done pulse
  task automatic ack_width();
    int n;
    n = 0;
    c = 8'h00;
    while (ack_n !== 1'b0 && n < 300)
    begin
      tick(1);
      n++;
    end
    gap = n;
    while (ack_n === 1'b0 && c < 8'hff)
    begin
      if (tx_ready === 1'b1)
        seen_ready = 1'b1;
      tick(1);
      c++;
    end
  endtask

  function automatic logic [3:0] nib_of(logic [7:0] v, logic hi);
    return hi ? v[7:4] : v[3:0];
  endfunction

  task automatic finish_rx();
    rx_ready = 1'b1;
    tick(1);
    rx_ready = 1'b0;
    chk(busy, 1'b1);
    ack_width();
    chk(c, 8'(ppp_pkg::ACK_CYC));
    chk(busy, 1'b0);
    chk(rx_valid, 1'b0);
  endtask

  task automatic rx_one(input logic [7:0] v);
    host.send(v, 1'b1);
    chk(rx_valid, 1'b1);
    chk(rx_data, v);
    chk(busy, 1'b1);
  endtask

  initial
  begin
    {srst, prime_n, selin_n, prime_en, nib, online} = 6'b110001;
    {paper_out, alarm, rx_ready, tx_valid, rev_en} = 5'h00;
    {tx_data, rev_data, seen_ready} = 17'h00000;
    void'($urandom(98786));
    tick(8);
    srst = 1'b0;
    tick(8);
    for (int i = 0; i < 4; i++)
    begin
      b = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($urandom);
      rx_one(b);
      finish_rx();
    end
    online = 1'b0;
    tick(2);
    chk({busy, sel}, 2'b10);
    online = 1'b1;
    tick(2);
    chk({busy, sel}, 2'b01);
    alarm = 1'b1;
    paper_out = 1'b1;
    tick(2);
    chk({paper_end, fault_n}, 2'b10);
    {alarm, paper_out} = 2'b00;
    selin_n = 1'b1;
    tick(6);
    chk(busy, 1'b1);
    host.send(8'($urandom), 1'b0);
    chk(rx_valid, 1'b0);
    selin_n = 1'b0;
    prime_en = 1'b1;
    tick(6);
    rx_one(8'($urandom));
    prime_n = 1'b0;
    tick(8);
    chk(rx_valid, 1'b0);
    prime_n = 1'b1;
    prime_en = 1'b0;
    tick(8);
    chk(busy, 1'b0);
    rx_one(8'($urandom));
    prime_n = 1'b0;
    tick(8);
    chk(rx_valid, 1'b1);
    prime_n = 1'b1;
    tick(8);
    finish_rx();
    nib = 1'b1;
    for (int i = 0; i < 3; i++)
    begin
      b = (i == 0) ? 8'h5a : 8'($urandom);
      tx_data = b;
      tx_valid = 1'b1;
      tick(1);
      tx_valid = 1'b0;
      tick(1);
      chk({busy, paper_end, sel, fault_n}, nib_of(b, 1'b0));
      ack_width();
      chk(c, 8'(ppp_pkg::ACK_CYC));
      chk({busy, paper_end, sel, fault_n}, nib_of(b, 1'b1));
      seen_ready = 1'b0;
      ack_width();
      chk(8'(gap), 8'(ppp_pkg::NIB_CYC));
      chk(seen_ready, 1'b1);
    end
    chk(busy, 1'b1);
    rev_en = 1'b1;
    rev_data = 8'($urandom);
    tick(2);
    chk(data_oe, 1'b1);
    chk(data_o, rev_data);
    nib = 1'b0;
    tick(2);
    chk(data_oe, 1'b0);
    conclude();
  end
endmodule
`default_nettype wire
